// File: rtl/lpmcg_pkg.sv
// lpmcg_pkg: register map, field layouts, reset values and state codes
// for the low-power mode and clock gating block.
// assumes a single 20 MHz system clock and a 16-bit register port.
package lpmcg_pkg;

	// register port widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;

	// default sizes, overridable at the top module
	localparam int N_PERIPH = 12;
	localparam int N_GPIO = 16;
	localparam int I2C_INDEX = 7;
	localparam logic [15:0] SERIAL_MASK = 16'h00F0;

	// register offsets
	localparam logic [7:0] ADDR_PCLK_EN = 8'h00;
	localparam logic [7:0] ADDR_LSP_PRE = 8'h01;
	localparam logic [7:0] ADDR_LPM_SEL = 8'h02;
	localparam logic [7:0] ADDR_CLK_CTL = 8'h03;
	localparam logic [7:0] ADDR_GPIO_WAKE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h05;

	// reset values
	localparam logic [15:0] RST_PCLK_EN = 16'h0000;
	localparam logic [2:0] RST_LSP_PRE = 3'h2;
	localparam logic [1:0] RST_LPM_SEL = 2'h0;
	localparam logic [15:0] RST_CLK_CTL = 16'h0000;
	localparam logic [15:0] RST_GPIO_WAKE = 16'h0000;

	// field positions
	localparam int LSP_PRE_W = 3;
	localparam int LPM_SEL_W = 2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_CAUSE_LSB = 4;

	// low-power mode codes written to the mode select register
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_STANDBY = 2'h1;
	localparam logic [1:0] MODE_HALT = 2'h2;

	// clock source codes
	localparam logic [1:0] SRC_INTOSC1 = 2'h0;
	localparam logic [1:0] SRC_INTOSC2 = 2'h1;
	localparam logic [1:0] SRC_XTAL = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;

	// clock control register layout
	typedef struct packed {
		logic [11:0] reserved;
		logic [1:0] clk_src;
		logic [1:0] osc_keep_running_in_shutdown;
	} lpmcg_clock_control_reg_s;

	// wake cause record, one bit per source class
	typedef struct packed {
		logic gpio;
		logic xint;
		logic wdog;
		logic periph;
	} lpmcg_wake_s;

	// clocking states, gray along run-idle-standby-halt
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_IDLE = 2'b01,
		ST_STANDBY = 2'b11,
		ST_HALT = 2'b10
	} lpmcg_state_e;

endpackage : lpmcg_pkg

// File: rtl/lpmcg_top.sv
// lpmcg_top: low-power mode sequencer and peripheral clock gating.
// assumes all inputs synchronous to i_clk; gated outputs drive clock-gate cells.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module lpmcg_top #(
	parameter int N_PERIPH = lpmcg_pkg::N_PERIPH,
	parameter int N_GPIO = lpmcg_pkg::N_GPIO,
	parameter int I2C_INDEX = lpmcg_pkg::I2C_INDEX,
	parameter logic [15:0] SERIAL_MASK = lpmcg_pkg::SERIAL_MASK
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// register port
	input wire logic [lpmcg_pkg::ADDR_W-1:0] i_addr,
	input wire logic [lpmcg_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [lpmcg_pkg::DATA_W-1:0] o_rdata,
	// cpu and wake sources
	input wire logic i_idle_req,
	input wire logic [N_PERIPH-1:0] i_periph_irq,
	input wire logic i_wdog_irq,
	input wire logic i_wdog_wake,
	input wire logic i_xint_event,
	input wire logic [N_GPIO-1:0] i_gpio,
	// clock gating outputs
	output logic o_cpu_clk_en,
	output logic [N_PERIPH-1:0] o_periph_clk_en,
	output logic o_lsp_tick,
	output logic o_wdog_clk_en,
	// oscillator controls
	output logic [1:0] o_intosc_run,
	output logic o_xtal_run,
	output logic o_pll_run,
	// state view
	output logic [1:0] o_lpm_state
);

	// map a mode select code to the state it enters; reserved code stays in run
	function automatic lpmcg_pkg::lpmcg_state_e mode_to_state(input logic [1:0] mode);
		case (mode)
			lpmcg_pkg::MODE_IDLE: mode_to_state = lpmcg_pkg::ST_IDLE;
			lpmcg_pkg::MODE_STANDBY: mode_to_state = lpmcg_pkg::ST_STANDBY;
			lpmcg_pkg::MODE_HALT: mode_to_state = lpmcg_pkg::ST_HALT;
			default: mode_to_state = lpmcg_pkg::ST_RUN;
		endcase
	endfunction : mode_to_state

	// whether the clock source code selects an internal oscillator that is kept running in halt
	function automatic logic intosc_selected(input logic [1:0] src, input logic [1:0] keep);
		case (src)
			lpmcg_pkg::SRC_INTOSC1: intosc_selected = keep[0];
			lpmcg_pkg::SRC_INTOSC2: intosc_selected = keep[1];
			default: intosc_selected = 1'b0;
		endcase
	endfunction : intosc_selected

	// software registers
	logic [N_PERIPH-1:0] periph_en;
	logic [lpmcg_pkg::LSP_PRE_W-1:0] lsp_pre;
	logic [lpmcg_pkg::LPM_SEL_W-1:0] lpm_sel;
	lpmcg_pkg::lpmcg_clock_control_reg_s clk_ctl;
	logic [N_GPIO-1:0] gpio_wake_mask;
	lpmcg_pkg::lpmcg_wake_s wake_cause;

	// state and derived terms
	lpmcg_pkg::lpmcg_state_e state;
	lpmcg_pkg::lpmcg_state_e next_state;
	logic [3:0] lsp_count;
	logic [3:0] lsp_limit;
	logic lsp_pulse;
	logic periph_clocks_on;
	logic wdog_alive_in_halt;
	logic idle_wake;
	logic gpio_wake;
	logic standby_wake;
	logic halt_wake;
	logic wake_now;
	lpmcg_pkg::lpmcg_wake_s next_cause;
	logic [lpmcg_pkg::DATA_W-1:0] rd_word;

	// peripheral clock enable register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			periph_en <= lpmcg_pkg::RST_PCLK_EN[N_PERIPH-1:0];
		else if (i_write && i_addr == lpmcg_pkg::ADDR_PCLK_EN)
			periph_en <= i_wdata[N_PERIPH-1:0];
	end

	// serial clock prescale register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			lsp_pre <= lpmcg_pkg::RST_LSP_PRE;
		else if (i_write && i_addr == lpmcg_pkg::ADDR_LSP_PRE)
			lsp_pre <= i_wdata[lpmcg_pkg::LSP_PRE_W-1:0];
	end

	// low-power mode select register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			lpm_sel <= lpmcg_pkg::RST_LPM_SEL;
		else if (i_write && i_addr == lpmcg_pkg::ADDR_LPM_SEL)
			lpm_sel <= i_wdata[lpmcg_pkg::LPM_SEL_W-1:0];
	end

	// clock control register; reserved bits held at zero
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			clk_ctl <= lpmcg_pkg::RST_CLK_CTL;
		else if (i_write && i_addr == lpmcg_pkg::ADDR_CLK_CTL)
		begin
			clk_ctl.reserved <= '0;
			clk_ctl.clk_src <= i_wdata[3:2];
			clk_ctl.osc_keep_running_in_shutdown <= i_wdata[1:0];
		end
	end

	// gpio wake selection register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			gpio_wake_mask <= lpmcg_pkg::RST_GPIO_WAKE[N_GPIO-1:0];
		else if (i_write && i_addr == lpmcg_pkg::ADDR_GPIO_WAKE)
			gpio_wake_mask <= i_wdata[N_GPIO-1:0];
	end

	// wake qualification per mode
	always_comb
	begin
		// only peripherals still clocked can raise an idle wake
		idle_wake = (|(i_periph_irq & periph_en)) | i_wdog_irq;
		gpio_wake = |(i_gpio & gpio_wake_mask);
		standby_wake = i_xint_event | gpio_wake;
		// a watchdog with a stopped clock cannot wake anything
		wdog_alive_in_halt = intosc_selected(clk_ctl.clk_src,
			clk_ctl.osc_keep_running_in_shutdown);
		halt_wake = gpio_wake | (i_wdog_wake & wdog_alive_in_halt);
	end

	// next clocking state
	always_comb
	begin
		next_state = state;
		wake_now = 1'b0;
		case (state)
			lpmcg_pkg::ST_RUN:
			begin
				if (i_idle_req)
					next_state = mode_to_state(lpm_sel);
			end
			lpmcg_pkg::ST_IDLE:
			begin
				wake_now = idle_wake;
			end
			lpmcg_pkg::ST_STANDBY:
			begin
				wake_now = standby_wake;
			end
			lpmcg_pkg::ST_HALT:
			begin
				wake_now = halt_wake;
			end
			default:
			begin
				next_state = lpmcg_pkg::ST_RUN;
			end
		endcase
		if (wake_now)
			next_state = lpmcg_pkg::ST_RUN;
	end

	// state register; reset also brings the block out of halt
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			state <= lpmcg_pkg::ST_RUN;
		else
			state <= next_state;
	end

	// cause of the most recent wake, kept until the next one
	always_comb
	begin
		next_cause.periph = (state == lpmcg_pkg::ST_IDLE) && (|(i_periph_irq & periph_en));
		next_cause.wdog = ((state == lpmcg_pkg::ST_IDLE) && i_wdog_irq)
			|| ((state == lpmcg_pkg::ST_HALT) && i_wdog_wake && wdog_alive_in_halt);
		next_cause.xint = (state == lpmcg_pkg::ST_STANDBY) && i_xint_event;
		next_cause.gpio = ((state == lpmcg_pkg::ST_STANDBY) || (state == lpmcg_pkg::ST_HALT))
			&& gpio_wake;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			wake_cause <= '0;
		else if (wake_now)
			wake_cause <= next_cause;
	end

	// serial divider: code 0 passes every cycle, code n divides by 2n
	always_comb
	begin
		if (lsp_pre == '0)
			lsp_limit = 4'h0;
		else
			lsp_limit = 4'({lsp_pre, 1'b0} - 4'h1);
	end

	// divider counts only while peripheral clocks run, so it is held at zero in standby and halt
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			lsp_count <= 4'h0;
		else if (!periph_clocks_on || lsp_count >= lsp_limit)
			lsp_count <= 4'h0;
		else
			lsp_count <= lsp_count + 4'h1;
	end

	assign lsp_pulse = periph_clocks_on && (lsp_count >= lsp_limit);

	// peripheral clocks live in run and idle only
	assign periph_clocks_on = (state == lpmcg_pkg::ST_RUN) || (state == lpmcg_pkg::ST_IDLE);

	// per-peripheral gates; serial ports take the divided tick, two-wire bus does not
	for (genvar gi = 0; gi < N_PERIPH; gi++)
	begin : g_periph_gate
		if (SERIAL_MASK[gi] && gi != I2C_INDEX)
		begin : g_serial
			assign o_periph_clk_en[gi] = periph_en[gi] & lsp_pulse;
		end
		else
		begin : g_plain
			assign o_periph_clk_en[gi] = periph_en[gi] & periph_clocks_on;
		end
	end

	// cpu clock runs only in run state; wake restores it one edge after detection
	assign o_cpu_clk_en = (state == lpmcg_pkg::ST_RUN);
	assign o_lsp_tick = lsp_pulse;

	// oscillators and pll: only halt stops them, internal ones unless kept
	always_comb
	begin
		o_pll_run = (state != lpmcg_pkg::ST_HALT);
		o_xtal_run = (state != lpmcg_pkg::ST_HALT);
		for (int k = 0; k < 2; k++)
			o_intosc_run[k] = (state != lpmcg_pkg::ST_HALT)
				|| clk_ctl.osc_keep_running_in_shutdown[k];
		// watchdog clock source must match cpu source; software sees to that
		o_wdog_clk_en = (state != lpmcg_pkg::ST_HALT) || wdog_alive_in_halt;
	end

	assign o_lpm_state = state;

	// read mux; unmapped addresses read as zero
	always_comb
	begin
		rd_word = '0;
		case (i_addr)
			lpmcg_pkg::ADDR_PCLK_EN: rd_word[N_PERIPH-1:0] = periph_en;
			lpmcg_pkg::ADDR_LSP_PRE: rd_word[lpmcg_pkg::LSP_PRE_W-1:0] = lsp_pre;
			lpmcg_pkg::ADDR_LPM_SEL: rd_word[lpmcg_pkg::LPM_SEL_W-1:0] = lpm_sel;
			lpmcg_pkg::ADDR_CLK_CTL: rd_word = clk_ctl;
			lpmcg_pkg::ADDR_GPIO_WAKE: rd_word[N_GPIO-1:0] = gpio_wake_mask;
			lpmcg_pkg::ADDR_STATUS:
			begin
				rd_word[lpmcg_pkg::STAT_STATE_LSB +: 2] = state;
				rd_word[lpmcg_pkg::STAT_CAUSE_LSB +: 4] = wake_cause;
			end
			default: rd_word = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			o_rdata <= '0;
		else if (i_read)
			o_rdata <= rd_word;
		else
			o_rdata <= '0;
	end

endmodule : lpmcg_top

// File: test/lpmcg_checker.sv
// lpmcg_checker: mode sequencing and clock gating assertions
// assumes lpmcg_top ports and one clock domain
`timescale 1ns/1ps
module lpmcg_checker #(
	parameter int N_PERIPH = 12,
	parameter int I2C_INDEX = 7
) (
	// clock, reset and register writes
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_write,
	// wake and request inputs
	input wire logic i_idle_req,
	input wire logic i_wdog_irq,
	input wire logic i_xint_event,
	// gating outputs
	input wire logic o_cpu_clk_en,
	input wire logic [N_PERIPH-1:0] o_periph_clk_en,
	input wire logic o_wdog_clk_en,
	input wire logic [1:0] o_intosc_run,
	input wire logic o_xtal_run,
	input wire logic o_pll_run,
	input wire logic [1:0] o_lpm_state
);
	logic [15:0] pen;
	logic [1:0] sel;
	logic [3:0] ctl;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// shadow of software settings, only writes are watched
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			pen <= 16'h0000;
			sel <= 2'h0;
			ctl <= 4'h0;
		end
		else if (i_write)
		begin
			if (i_addr == 8'h00) pen <= i_wdata;
			if (i_addr == 8'h02) sel <= i_wdata[1:0];
			if (i_addr == 8'h03) ctl <= i_wdata[3:0];
		end
	end

	property p_cpu_gate;
		o_cpu_clk_en == (o_lpm_state == 2'h0);
	endproperty
	a_cpu_gate: assert property (p_cpu_gate) else $error("cpu enable off state");
	property p_entry;
		o_lpm_state == 2'h0 && i_idle_req && sel != 2'h3 |=>
			o_lpm_state == (sel == 2'h0 ? 2'h1 : (sel == 2'h1 ? 2'h3 : 2'h2));
	endproperty
	a_entry: assert property (p_entry) else $error("wrong mode entered");
	property p_stby_off;
		o_lpm_state == 2'h3 |-> o_periph_clk_en == '0;
	endproperty
	a_stby_off: assert property (p_stby_off) else $error("standby clock on");
	property p_osc_on;
		o_lpm_state != 2'h2 |-> o_pll_run && o_xtal_run;
	endproperty
	a_osc_on: assert property (p_osc_on) else $error("oscillator stopped");
	property p_halt_osc;
		o_lpm_state == 2'h2 && !ctl[3] |-> !o_xtal_run && o_intosc_run == ctl[1:0];
	endproperty
	a_halt_osc: assert property (p_halt_osc) else $error("halt osc wrong");
	property p_wdog;
		o_lpm_state == 2'h2 |-> o_wdog_clk_en == (!ctl[3] && ctl[ctl[2]]);
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog clock wrong");
	property p_idle_wake;
		o_lpm_state == 2'h1 && i_wdog_irq |=> o_lpm_state == 2'h0;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle kept");
	property p_stby_wake;
		o_lpm_state == 2'h3 && i_xint_event |=> o_lpm_state == 2'h0 && o_cpu_clk_en;
	endproperty
	a_stby_wake: assert property (p_stby_wake) else $error("standby kept");
	property p_plain_en;
		!o_lpm_state[1] |-> o_periph_clk_en[I2C_INDEX] == pen[I2C_INDEX];
	endproperty
	a_plain_en: assert property (p_plain_en) else $error("two-wire enable");
endmodule : lpmcg_checker

bind lpmcg_top lpmcg_checker #(.N_PERIPH(N_PERIPH), .I2C_INDEX(I2C_INDEX)) u_chk (
	.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_write(i_write), .i_idle_req(i_idle_req), .i_wdog_irq(i_wdog_irq),
	.i_xint_event(i_xint_event), .o_cpu_clk_en(o_cpu_clk_en),
	.o_periph_clk_en(o_periph_clk_en), .o_wdog_clk_en(o_wdog_clk_en),
	.o_intosc_run(o_intosc_run), .o_xtal_run(o_xtal_run), .o_pll_run(o_pll_run),
	.o_lpm_state(o_lpm_state));

// File: test/testbench.sv
// testbench: directed scenarios for low-power modes and clock gating
// assumes lpmcg_top default sizes, checker bound separately
`timescale 1ns/1ps
module testbench;
	logic i_clk, i_reset, i_write, i_read, i_idle_req, i_wdog_irq, i_wdog_wake, i_xint_event;
	logic [7:0] i_addr;
	logic [15:0] i_wdata, o_rdata, i_gpio;
	logic [11:0] i_periph_irq, o_periph_clk_en;
	logic o_cpu_clk_en, o_lsp_tick, o_wdog_clk_en, o_xtal_run, o_pll_run;
	logic [1:0] o_intosc_run, o_lpm_state;
	int error_cnt;
	int checks;

	lpmcg_top DUT (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_idle_req(i_idle_req),
		.i_periph_irq(i_periph_irq), .i_wdog_irq(i_wdog_irq), .i_wdog_wake(i_wdog_wake),
		.i_xint_event(i_xint_event), .i_gpio(i_gpio), .o_cpu_clk_en(o_cpu_clk_en),
		.o_periph_clk_en(o_periph_clk_en), .o_lsp_tick(o_lsp_tick),
		.o_wdog_clk_en(o_wdog_clk_en), .o_intosc_run(o_intosc_run), .o_xtal_run(o_xtal_run),
		.o_pll_run(o_pll_run), .o_lpm_state(o_lpm_state));

	task automatic complete_run();
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clk);
		i_write <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clk);
		i_read <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask : rdc

	task automatic req();
		@(posedge i_clk);
		i_idle_req <= 1'b1;
		@(posedge i_clk);
		i_idle_req <= 1'b0;
		#1;
	endtask : req

	// one-cycle wake pattern: w is {wdog_irq, wdog_wake, xint}
	task automatic hit(input logic [11:0] irq, input logic [2:0] w, input logic [15:0] g);
		@(posedge i_clk);
		i_periph_irq <= irq;
		{i_wdog_irq, i_wdog_wake, i_xint_event} <= w;
		i_gpio <= g;
		@(posedge i_clk);
		i_periph_irq <= 12'h000;
		{i_wdog_irq, i_wdog_wake, i_xint_event} <= 3'h0;
		i_gpio <= 16'h0000;
		#1;
	endtask : hit

	task automatic st(input logic [2:0] e);
		chk({13'h0000, o_cpu_clk_en, o_lpm_state}, {13'h0000, e});
	endtask : st

	task automatic t_regs();
		rdc(lpmcg_pkg::ADDR_LSP_PRE, 16'h0002);
		rdc(lpmcg_pkg::ADDR_CLK_CTL, 16'h0000);
		wr(8'h3C, 16'hFFFF);
		rdc(8'h3C, 16'h0000);
		wr(lpmcg_pkg::ADDR_LPM_SEL, 16'h0003);
		rdc(lpmcg_pkg::ADDR_LPM_SEL, 16'h0003);
		req();
		st(3'h4);
	endtask : t_regs

	task automatic t_idle();
		wr(lpmcg_pkg::ADDR_PCLK_EN, 16'h0081);
		wr(lpmcg_pkg::ADDR_LPM_SEL, 16'h0000);
		req();
		st(3'h1);
		chk({4'h0, o_periph_clk_en}, 16'h0081);
		hit(12'h002, 3'h0, 16'h0000);
		st(3'h1);
		hit(12'h000, 3'h4, 16'h0000);
		st(3'h4);
		req();
		hit(12'h001, 3'h0, 16'h0000);
		st(3'h4);
	endtask : t_idle

	// serial enables tick at the divided rate, the two-wire one stays plain
	task automatic t_lsp();
		int n4;
		int n7;
		int nt;
		wr(lpmcg_pkg::ADDR_PCLK_EN, 16'h0090);
		for (int p = 0; p < 3; p++)
		begin
			wr(lpmcg_pkg::ADDR_LSP_PRE, 16'(p));
			n4 = 0;
			n7 = 0;
			nt = 0;
			repeat (24)
			begin
				@(posedge i_clk);
				#1;
				n4 += int'(o_periph_clk_en[4]);
				n7 += int'(o_periph_clk_en[7]);
				nt += int'(o_lsp_tick);
			end
			chk(16'(n4), 16'(p == 0 ? 24 : 12 / p));
			chk(16'(nt), 16'(p == 0 ? 24 : 12 / p));
			chk(16'(n7), 16'h0018);
		end
	endtask : t_lsp

	task automatic t_stby();
		wr(lpmcg_pkg::ADDR_PCLK_EN, 16'h0FFF);
		wr(lpmcg_pkg::ADDR_GPIO_WAKE, 16'h0008);
		wr(lpmcg_pkg::ADDR_LPM_SEL, 16'h0001);
		req();
		st(3'h3);
		chk({4'h0, o_periph_clk_en}, 16'h0000);
		chk({14'h0000, o_pll_run, o_xtal_run}, 16'h0003);
		hit(12'h000, 3'h4, 16'h0004);
		st(3'h3);
		hit(12'h000, 3'h1, 16'h0000);
		st(3'h4);
		rdc(lpmcg_pkg::ADDR_STATUS, 16'h0040);
		req();
		hit(12'h000, 3'h0, 16'h0008);
		st(3'h4);
	endtask : t_stby

	task automatic t_halt();
		wr(lpmcg_pkg::ADDR_CLK_CTL, 16'h0001);
		wr(lpmcg_pkg::ADDR_LPM_SEL, 16'h0002);
		req();
		st(3'h2);
		chk({13'h0000, o_intosc_run, o_xtal_run}, 16'h0002);
		chk({15'h0000, o_wdog_clk_en}, 16'h0001);
		hit(12'h000, 3'h2, 16'h0000);
		st(3'h4);
		wr(lpmcg_pkg::ADDR_CLK_CTL, 16'h0000);
		req();
		chk({13'h0000, o_intosc_run, o_wdog_clk_en}, 16'h0000);
		hit(12'h000, 3'h3, 16'h0004);
		st(3'h2);
		hit(12'h000, 3'h0, 16'h0008);
		st(3'h4);
		// second internal oscillator kept alive still clocks the watchdog
		wr(lpmcg_pkg::ADDR_CLK_CTL, 16'h0006);
		req();
		chk({13'h0000, o_intosc_run, o_wdog_clk_en}, 16'h0005);
		hit(12'h000, 3'h2, 16'h0000);
		st(3'h4);
		// crystal source: no keep option, watchdog dead, its wake ignored
		wr(lpmcg_pkg::ADDR_CLK_CTL, 16'h000B);
		req();
		chk({12'h000, o_intosc_run, o_xtal_run, o_wdog_clk_en}, 16'h000C);
		hit(12'h000, 3'h2, 16'h0000);
		st(3'h2);
		req();
		@(posedge i_clk);
		i_reset <= 1'b1;
		@(posedge i_clk);
		i_reset <= 1'b0;
		#1;
		st(3'h4);
		chk({4'h0, o_periph_clk_en}, 16'h0000);
	endtask : t_halt

	// free-running clock, 50 ns period
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// hang guard, well past the roughly 160 cycles of the run
	initial
	begin
		repeat (3000) @(posedge i_clk);
		error_cnt++;
		complete_run();
	end

	initial
	begin
		error_cnt = 0;
		checks = 0;
		i_reset = 1'b1;
		{i_addr, i_wdata, i_write, i_read, i_idle_req} = '0;
		{i_periph_irq, i_wdog_irq, i_wdog_wake, i_xint_event, i_gpio} = '0;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		t_regs();
		t_idle();
		t_lsp();
		t_stby();
		t_halt();
		complete_run();
	end
endmodule : testbench
